// ---- shared/adc_window_pkg.sv ----
package adc_window_pkg;

  // ****************************************************************
  // Register offsets on the special-function-register port
  // ****************************************************************
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hbd;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_CONTROL = 8'he8;
  localparam logic [7:0] ADDR_GREATER_LOW = 8'hc3;
  localparam logic [7:0] ADDR_GREATER_HIGH = 8'hc4;
  localparam logic [7:0] ADDR_LESS_LOW = 8'hc5;
  localparam logic [7:0] ADDR_LESS_HIGH = 8'hc6;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int CTRL_COMPLETE_BIT = 5;
  localparam int CTRL_WINDOW_BIT = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int RESULT_BITS = 10;
  localparam int WORD_BITS = 16;
  localparam int LEFT_PAD = WORD_BITS - RESULT_BITS;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] greater;
    logic [WORD_BITS-1:0] less;
  } limits_t;

  typedef struct packed {
    logic done;
    logic [RESULT_BITS-1:0] code;
  } conversion_t;

endpackage : adc_window_pkg

// ---- verilog/adc_window_compare.sv ----
`timescale 1ns/1ps
module adc_window_compare
  import adc_window_pkg::*;
(
  // Operands
  input wire logic [WORD_BITS-1:0] word_i,
  input wire adc_window_pkg::limits_t limits_i,
  input wire logic signed_mode_i,
  // Verdict
  output logic match_o
);

  function automatic logic less_than(input logic [WORD_BITS-1:0] a, input logic [WORD_BITS-1:0] b,
                                     input logic is_signed);
    if (is_signed) begin
      less_than = $signed(a) < $signed(b);
    end else begin
      less_than = a < b;
    end
  endfunction : less_than

  logic band_inside;

  always_comb begin
    // The ordering of the two limits alone picks inside or outside
    band_inside = less_than(limits_i.greater, limits_i.less, signed_mode_i);
    if (band_inside) begin
      match_o = less_than(limits_i.greater, word_i, signed_mode_i)
                && less_than(word_i, limits_i.less, signed_mode_i);
    end else begin
      match_o = less_than(word_i, limits_i.less, signed_mode_i)
                || less_than(limits_i.greater, word_i, signed_mode_i);
    end
  end

endmodule : adc_window_compare

// ---- verilog/adc_window_detector.sv ----
`timescale 1ns/1ps
// Contract
// - Every finished conversion is compared to the limits with no software help.
// - The window match sits as a flag bit in the converter control register.
// - Greater-than and less-than limits are each a writable high and low byte.
// - Limit ordering alone selects inside or outside matching; no mode bit.
// - Single-ended results and limits compare as 16-bit unsigned register words.
// - Differential results and limits compare as 16-bit two's complement register words.
// - Less limit above greater limit: flag only strictly between the two.
// - Greater limit above less limit: flag below less or above greater.
module adc_window_detector
  import adc_window_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire adc_window_pkg::sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  // Converter side
  input wire adc_window_pkg::conversion_t conv_i,
  input wire logic left_justify_i,
  input wire logic differential_i,
  // Status
  output logic [7:0] control_o,
  output logic window_match_flag_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Control register and its flags
  logic [7:0] converter_control;
  logic [7:0] next_converter_control;
  // Conversion word as software reads it
  logic [WORD_BITS-1:0] result_word;
  logic [WORD_BITS-1:0] next_result_word;
  // Programmed window limits
  limits_t limits;
  limits_t next_limits;
  // Read data and status copies
  logic [7:0] next_sfr_rdata;
  logic [7:0] next_control;
  logic next_window_match_flag;
  // Comparison path
  logic [WORD_BITS-1:0] formatted;
  logic window_hit;
  // Decoded write strobes
  logic control_wr;
  logic result_low_wr;
  logic result_high_wr;
  logic greater_low_wr;
  logic greater_high_wr;
  logic less_low_wr;
  logic less_high_wr;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Place a raw code in the register word the way software reads it
  function automatic logic [WORD_BITS-1:0] format_code(input logic [RESULT_BITS-1:0] code,
                                                       input logic left, input logic diff);
    if (left) begin
      format_code = {code, {LEFT_PAD{1'b0}}};
    end else if (diff) begin
      format_code = {{LEFT_PAD{code[RESULT_BITS-1]}}, code};
    end else begin
      format_code = {{LEFT_PAD{1'b0}}, code};
    end
  endfunction : format_code

  function automatic logic hit(input sfr_req_t req, input logic [7:0] addr);
    hit = req.wr && (req.addr == addr);
  endfunction : hit

  // Replace one byte lane of a 16-bit register word
  function automatic logic [WORD_BITS-1:0] put_byte(input logic [WORD_BITS-1:0] word, input logic upper,
                                                    input logic [7:0] data);
    logic [WORD_BITS-1:0] merged;
    merged = word;
    if (upper) begin
      merged[WORD_BITS-1:8] = data;
    end else begin
      merged[7:0] = data;
    end
    put_byte = merged;
  endfunction : put_byte

  // Pick one byte lane of a 16-bit register word for a read
  function automatic logic [7:0] get_byte(input logic [WORD_BITS-1:0] word, input logic upper);
    if (upper) begin
      get_byte = word[WORD_BITS-1:8];
    end else begin
      get_byte = word[7:0];
    end
  endfunction : get_byte

  // ****************************************************************
  // Write decode
  // ****************************************************************
  always_comb begin
    control_wr = hit(sfr_req_i, ADDR_CONTROL);
    result_low_wr = hit(sfr_req_i, ADDR_RESULT_LOW);
    result_high_wr = hit(sfr_req_i, ADDR_RESULT_HIGH);
    greater_low_wr = hit(sfr_req_i, ADDR_GREATER_LOW);
    greater_high_wr = hit(sfr_req_i, ADDR_GREATER_HIGH);
    less_low_wr = hit(sfr_req_i, ADDR_LESS_LOW);
    less_high_wr = hit(sfr_req_i, ADDR_LESS_HIGH);
  end

  // ****************************************************************
  // Comparison
  // ****************************************************************
  // Limits are compared in the same format as the result, so a mismatch
  // between software format and converter format gives wrong verdicts.
  always_comb begin
    formatted = format_code(conv_i.code, left_justify_i, differential_i);
  end

  adc_window_compare u_compare (
    .word_i(formatted),
    .limits_i(limits),
    .signed_mode_i(differential_i),
    .match_o(window_hit)
  );

  // ****************************************************************
  // Control register
  // ****************************************************************
  // A conversion landing with a clearing write still sets its flags, so a
  // clear issued at the wrong moment can never swallow an event.
  always_comb begin
    next_converter_control = converter_control;
    if (control_wr) begin
      next_converter_control = sfr_req_i.wdata;
    end
    if (conv_i.done) begin
      next_converter_control[CTRL_COMPLETE_BIT] = 1'b1;
      if (window_hit) begin
        next_converter_control[CTRL_WINDOW_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      converter_control <= CONTROL_RESET;
    end else begin
      converter_control <= next_converter_control;
    end
  end

  // ****************************************************************
  // Conversion result
  // ****************************************************************
  always_comb begin
    next_result_word = result_word;
    if (result_low_wr) begin
      next_result_word = put_byte(next_result_word, 1'b0, sfr_req_i.wdata);
    end
    if (result_high_wr) begin
      next_result_word = put_byte(next_result_word, 1'b1, sfr_req_i.wdata);
    end
    // A finished conversion beats a software write in the same cycle
    if (conv_i.done) begin
      next_result_word = formatted;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      result_word <= {BYTE_RESET, BYTE_RESET};
    end else begin
      result_word <= next_result_word;
    end
  end

  // ****************************************************************
  // Window limits
  // ****************************************************************
  always_comb begin
    next_limits = limits;
    if (greater_low_wr) begin
      next_limits.greater = put_byte(next_limits.greater, 1'b0, sfr_req_i.wdata);
    end
    if (greater_high_wr) begin
      next_limits.greater = put_byte(next_limits.greater, 1'b1, sfr_req_i.wdata);
    end
    if (less_low_wr) begin
      next_limits.less = put_byte(next_limits.less, 1'b0, sfr_req_i.wdata);
    end
    if (less_high_wr) begin
      next_limits.less = put_byte(next_limits.less, 1'b1, sfr_req_i.wdata);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      limits <= '0;
    end else begin
      limits <= next_limits;
    end
  end

  // ****************************************************************
  // Read data and status outputs
  // ****************************************************************
  // Control reads show the post-update value, so a flag set in the same
  // cycle is never missed by a polling read.
  always_comb begin
    unique case (sfr_req_i.addr)
      ADDR_CONTROL: next_sfr_rdata = next_converter_control;
      ADDR_RESULT_LOW: next_sfr_rdata = get_byte(result_word, 1'b0);
      ADDR_RESULT_HIGH: next_sfr_rdata = get_byte(result_word, 1'b1);
      ADDR_GREATER_LOW: next_sfr_rdata = get_byte(limits.greater, 1'b0);
      ADDR_GREATER_HIGH: next_sfr_rdata = get_byte(limits.greater, 1'b1);
      ADDR_LESS_LOW: next_sfr_rdata = get_byte(limits.less, 1'b0);
      ADDR_LESS_HIGH: next_sfr_rdata = get_byte(limits.less, 1'b1);
      default: next_sfr_rdata = UNMAPPED_READ;
    endcase
    if (!sfr_req_i.rd) begin
      next_sfr_rdata = sfr_rdata_o;
    end
    next_control = next_converter_control;
    next_window_match_flag = next_converter_control[CTRL_WINDOW_BIT];
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= BYTE_RESET;
      control_o <= CONTROL_RESET;
      window_match_flag_o <= 1'b0;
    end else begin
      sfr_rdata_o <= next_sfr_rdata;
      control_o <= next_control;
      window_match_flag_o <= next_window_match_flag;
    end
  end

endmodule : adc_window_detector

// ---- verification/adc_window_detector_asserts.sv ----
`timescale 1ns/1ps
module adc_window_detector_asserts
  import adc_window_pkg::*;
(
  // Watched ports
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire adc_window_pkg::sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire adc_window_pkg::conversion_t conv_i,
  input wire logic left_justify_i,
  input wire logic differential_i,
  input wire logic [7:0] control_o,
  input wire logic window_match_flag_o
);
  // ****
  // Checks
  // ****
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ctl_wr = sfr_req_i.wr && sfr_req_i.addr == ADDR_CONTROL;
  sequence s_limit_wr;
    sfr_req_i.wr && sfr_req_i.addr inside {[ADDR_GREATER_LOW:ADDR_LESS_HIGH]};
  endsequence
  sequence s_same_rd;
    sfr_req_i.rd && sfr_req_i.addr == $past(sfr_req_i.addr);
  endsequence
  a_flag_mirror: assert property (window_match_flag_o == control_o[CTRL_WINDOW_BIT])
    else $error("flag and control bit differ");
  a_done_complete: assert property (conv_i.done |=> control_o[CTRL_COMPLETE_BIT])
    else $error("complete bit not set");
  a_flag_sticky: assert property (window_match_flag_o && !ctl_wr |=> window_match_flag_o)
    else $error("flag dropped");
  a_flag_cause: assert property ($rose(window_match_flag_o) |-> $past(conv_i.done) || $past(ctl_wr))
    else $error("flag rose alone");
  a_flag_clear: assert property (ctl_wr && !sfr_req_i.wdata[CTRL_WINDOW_BIT] && !conv_i.done |=> !window_match_flag_o)
    else $error("flag not cleared");
  a_ctrl_read: assert property (sfr_req_i.rd && sfr_req_i.addr == ADDR_CONTROL |=> sfr_rdata_o == control_o)
    else $error("control read wrong");
  a_limit_back: assert property (s_limit_wr ##1 s_same_rd |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("limit read wrong");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n_i |=> control_o == CONTROL_RESET)
    else $error("control not reset");
endmodule : adc_window_detector_asserts
bind adc_window_detector adc_window_detector_asserts u_asserts (.core_clk_i, .rst_n_i, .sfr_req_i, .sfr_rdata_o,
  .conv_i, .left_justify_i, .differential_i, .control_o, .window_match_flag_o);

// ---- verification/adc_window_detector_test.sv ----
`timescale 1ns/1ps
module adc_window_detector_test;
  import adc_window_pkg::*;
  // ****
  // Rows: limits, mode {differential, left}, code, expected flag
  // ****
  typedef struct packed {logic [15:0] gt; logic [15:0] lt; logic [1:0] mode; logic [9:0] code; logic hit;} row_t;
  localparam row_t ROWS [10] = '{'{16'h0040, 16'h0080, 2'h0, 10'h050, 1'h1},
    '{16'h0040, 16'h0080, 2'h0, 10'h040, 1'h0}, '{16'h0040, 16'h0080, 2'h0, 10'h080, 1'h0},
    '{16'h0080, 16'h0040, 2'h0, 10'h030, 1'h1}, '{16'h0080, 16'h0040, 2'h0, 10'h060, 1'h0},
    '{16'h0100, 16'h03ff, 2'h0, 10'h200, 1'h1}, '{16'hffff, 16'h0040, 2'h2, 10'h000, 1'h1},
    '{16'hffff, 16'h0040, 2'h2, 10'h3c0, 1'h0}, '{16'hffc0, 16'h1000, 2'h3, 10'h000, 1'h1},
    '{16'h1000, 16'h2000, 2'h1, 10'h050, 1'h1}};
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, left_justify_i = 1'b0, differential_i = 1'b0;
  sfr_req_t sfr_req_i = '0;
  conversion_t conv_i = '0;
  logic [7:0] sfr_rdata_o, control_o;
  logic window_match_flag_o;
  logic [15:0] word;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  adc_window_detector u_dut (.core_clk_i, .rst_n_i, .sfr_req_i, .sfr_rdata_o, .conv_i, .left_justify_i,
    .differential_i, .control_o, .window_match_flag_o);
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Each request holds for one edge; the next task replaces it, so no gap cycles
  task automatic drive(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [10:0] c);
    sfr_req_i = '{w, !w && !c[10], a, d};
    conv_i = c;
    @(posedge core_clk_i) #1;
  endtask : drive
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    check(control_o, CONTROL_RESET);
    foreach (ROWS[i]) begin
      {differential_i, left_justify_i} = ROWS[i].mode;
      word = ROWS[i].mode[0] ? {ROWS[i].code, 6'h00} : {{6{ROWS[i].mode[1] & ROWS[i].code[9]}}, ROWS[i].code};
      drive(1'b1, ADDR_CONTROL, 8'h00, 11'h000);
      drive(1'b1, ADDR_GREATER_HIGH, ROWS[i].gt[15:8], 11'h000);
      drive(1'b1, ADDR_GREATER_LOW, ROWS[i].gt[7:0], 11'h000);
      drive(1'b1, ADDR_LESS_HIGH, ROWS[i].lt[15:8], 11'h000);
      drive(1'b1, ADDR_LESS_LOW, ROWS[i].lt[7:0], 11'h000);
      drive(1'b0, 8'h00, 8'h00, {1'b1, ROWS[i].code});
      check(window_match_flag_o, ROWS[i].hit);
      drive(1'b0, ADDR_RESULT_LOW, 8'h00, 11'h000);
      check(sfr_rdata_o, word[7:0]);
      drive(1'b0, ADDR_RESULT_HIGH, 8'h00, 11'h000);
      check(sfr_rdata_o, word[15:8]);
    end
    drive(1'b0, 8'h00, 8'h00, 11'h7ff);
    check(window_match_flag_o, 1'h1);
    drive(1'b0, ADDR_CONTROL, 8'h00, 11'h000);
    check(sfr_rdata_o, 8'h28);
    drive(1'b1, ADDR_LESS_LOW, 8'h5a, 11'h000);
    drive(1'b0, ADDR_LESS_LOW, 8'h00, 11'h000);
    check(sfr_rdata_o, 8'h5a);
    drive(1'b1, ADDR_CONTROL, 8'h00, 11'h000);
    drive(1'b0, 8'h01, 8'h00, 11'h000);
    check({sfr_rdata_o, control_o}, {UNMAPPED_READ, 8'h00});
    // Clearing write and matching conversion in one cycle: the set wins
    drive(1'b1, ADDR_CONTROL, 8'h00, 11'h450);
    check(control_o, 8'h28);
    check(window_match_flag_o, 1'h1);
    // Reset in mid-run drops the flags and the limits
    rst_n_i = 1'b0;
    drive(1'b0, 8'h00, 8'h00, 11'h000);
    check({sfr_rdata_o, control_o}, {BYTE_RESET, CONTROL_RESET});
    check(window_match_flag_o, 1'h0);
    rst_n_i = 1'b1;
    drive(1'b0, ADDR_LESS_HIGH, 8'h00, 11'h000);
    check(sfr_rdata_o, BYTE_RESET);
    final_report();
  end
endmodule : adc_window_detector_test
